/* File: gpib_measurement_fifo.sv */
// measurement store behind an instrument bus listener and talker
//
// Notes on behaviour
// - listening: ndac asserted, nrfd and dav released
// - upper listen address carries data into store
// - lower listen address carries program codes
// - unlisten or poll enable ends listening and releases ndac and nrfd
// - untalked sources nothing; talked sources a byte
// - poll enabled talker sends the status byte
// - full or accumulating holds nrfd asserted at the data address only
// - full store refuses data until a byte is read or it is cleared
// - halt code stops source transfer
// - clear code, selected or universal clear empty
// - status reads 010 one byte, 0 after clear
// - clear zeroes both address counters
// - all eight data bits kept independently
// - first byte after clear returned first
// - binary format returns bytes in order unconverted
// - digit transfer code sets digits per transfer
// - binary format: eoi with last byte
`timescale 1ns/1ps
`include "gpib_fifo_defs.svh"
module gpib_measurement_fifo #(
  parameter int ADDR_W = 11
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // interrupt
  output logic             irq,
  // instrument bus, open drain, low on the wire is asserted
  input  wire logic [7:0]  dio_in,
  output logic      [7:0]  dio_out,
  output logic      [7:0]  dio_oe,
  input  wire logic        dav_in,
  output logic             dav_out,
  output logic             dav_oe,
  input  wire logic        nrfd_in,
  output logic             nrfd_out,
  output logic             nrfd_oe,
  input  wire logic        ndac_in,
  output logic             ndac_out,
  output logic             ndac_oe,
  output logic             eoi_out,
  output logic             eoi_oe,
  input  wire logic        atn_in,
  input  wire logic        ifc_in,
  // measurement source
  input  wire logic        meas_valid,
  input  wire logic [7:0]  meas_data,
  output logic             meas_ready
);
  localparam logic [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};
  localparam logic [ADDR_W:0] HALF  = {2'b01, {(ADDR_W-1){1'b0}}};
  localparam logic [ADDR_W:0] ONE   = {{ADDR_W{1'b0}}, 1'b1};

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [12:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
  wire  [12:0] pin_raw = {ifc_in, atn_in, dav_in, nrfd_in, ndac_in, dio_in};
  wire  [12:0] agree   = ~(sync2_reg ^ sync3_reg);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_reg <= `PIN_RESET;
      sync2_reg <= `PIN_RESET;
      sync3_reg <= `PIN_RESET;
      pin_reg   <= `PIN_RESET;
    end else if (ce) begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= (agree & sync3_reg) | (~agree & pin_reg);
    end
  end

  wire       ifc_a    = ~pin_reg[12];
  wire       atn_a    = ~pin_reg[11];
  wire       dav_a    = ~pin_reg[10];
  wire       nrfd_a   = ~pin_reg[9];
  wire       ndac_a   = ~pin_reg[8];
  wire [7:0] bus_byte = ~pin_reg[7:0];
  wire [6:0] cmd      = bus_byte[6:0];

  // ****************************************
  // state
  // ****************************************
  logic [5:0]  ctrl_reg, ctrl_next;
  logic        xfer_active_reg, xfer_active_next;
  logic        listen_reg, prog_listen_reg, talk_reg, spoll_reg;
  logic        listen_next, prog_listen_next, talk_next, spoll_next;
  logic [3:0]  fmt_reg, fmt_next, digits_reg, digits_next;
  logic [3:0]  int_stat_reg, int_stat_next, int_mask_reg, int_mask_next;
  logic        bus_wr_reg;
  logic [7:0]  bus_addr_reg;
  logic [7:0]  dio_oe_next;
  logic        eoi_oe_next, pin_low_reg;
  gpib_fifo_pkg::acpt_state_e acpt_state_reg, acpt_next;
  gpib_fifo_pkg::src_state_e  src_state_reg, src_next;
  gpib_fifo_pkg::prog_state_e prog_state_reg, prog_state_next;

  // ****************************************
  // store
  // ****************************************
  logic [ADDR_W:0] fifo_count;
  logic [7:0]      fifo_head;
  wire  empty     = fifo_count == '0;
  wire  full      = fifo_count == DEPTH;
  wire  over_half = fifo_count > HALF;
  // memory condition bits: low = stored and at most half, high = above
  wire  memory_condition_bit_low  = !empty && !over_half;
  wire  memory_condition_bit_high = over_half;
  wire  [7:0] status_byte = {3'h0, memory_condition_bit_high,
                             memory_condition_bit_low, 3'h0};

  // ****************************************
  // acceptor handshake and addressing
  // ****************************************
  wire enable    = ctrl_reg[`CTRL_ENABLE];
  wire [4:0] my_addr   = ctrl_reg[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
  wire [4:0] data_addr = my_addr + 5'h01;
  // program codes stay open so halt and clear reach a busy or full store
  wire hold_nrfd = !prog_listen_reg && (full || xfer_active_reg);
  wire engaged   = enable && !ifc_a && (atn_a || listen_reg);
  // commands are always taken; data waits while the store cannot take it
  wire take      = engaged && acpt_state_reg == gpib_fifo_pkg::ACPT_READY &&
                   dav_a && !nrfd_oe && (atn_a || !hold_nrfd);
  wire cmd_take  = take && atn_a;
  wire data_take = take && !atn_a && !prog_listen_reg;
  wire prog_take = take && !atn_a && prog_listen_reg;
  wire is_listen = cmd[6:5] == `GRP_LISTEN;
  wire is_talk   = cmd[6:5] == `GRP_TALK;
  wire my_lower  = is_listen && cmd[4:0] == my_addr;
  wire my_upper  = is_listen && cmd[4:0] == data_addr;
  wire my_talk   = is_talk && cmd[4:0] == my_addr;
  wire is_unl    = cmd_take && cmd == `CMD_UNL;
  wire is_spe    = cmd_take && cmd == `CMD_SPE;

  assign listen_next = (ifc_a || is_unl || is_spe) ? 1'b0 :
                       (cmd_take && (my_lower || my_upper)) ? 1'b1 :
                       listen_reg;
  assign prog_listen_next = (cmd_take && my_lower) ? 1'b1 :
                            (cmd_take && my_upper) ? 1'b0 : prog_listen_reg;
  // any other talk address, untalk among them, ends talking
  assign talk_next = (ifc_a || (cmd_take && is_talk && !my_talk)) ? 1'b0 :
                     (cmd_take && my_talk) ? 1'b1 : talk_reg;
  assign spoll_next = (ifc_a || (cmd_take && cmd == `CMD_SPD)) ? 1'b0 :
                      is_spe ? 1'b1 : spoll_reg;

  assign acpt_next = !engaged ? gpib_fifo_pkg::ACPT_READY :
                     take ? gpib_fifo_pkg::ACPT_HOLD :
                     !dav_a ? gpib_fifo_pkg::ACPT_READY : acpt_state_reg;
  wire ndac_oe_next = engaged &&
                      acpt_next == gpib_fifo_pkg::ACPT_READY;
  wire nrfd_oe_next = engaged && (acpt_next == gpib_fifo_pkg::ACPT_HOLD ||
                      (!atn_a && hold_nrfd));

  // ****************************************
  // program codes and clears
  // ****************************************
  wire pc_idle  = prog_state_reg == gpib_fifo_pkg::PROG_IDLE;
  wire pc_digit = bus_byte[7:4] == `PC_DIGIT_GRP;
  wire halt     = prog_take && pc_idle && bus_byte == `PC_HALT;
  wire pc_clear = prog_take && pc_idle && bus_byte == `PC_CLEAR;
  wire dev_clear = cmd_take && (cmd == `CMD_DCL ||
                   (cmd == `CMD_SDC && listen_reg));
  wire clr      = pc_clear || dev_clear;

  assign prog_state_next = !prog_take ? prog_state_reg :
    (pc_idle && bus_byte == `PC_FORMAT) ? gpib_fifo_pkg::PROG_FORMAT :
    (pc_idle && bus_byte == `PC_DIGITS) ? gpib_fifo_pkg::PROG_DIGITS :
    gpib_fifo_pkg::PROG_IDLE;
  assign fmt_next = (prog_take && pc_digit &&
    prog_state_reg == gpib_fifo_pkg::PROG_FORMAT) ? bus_byte[3:0] :
    fmt_reg;
  assign digits_next = (prog_take && pc_digit &&
    prog_state_reg == gpib_fifo_pkg::PROG_DIGITS) ? bus_byte[3:0] :
    digits_reg;

  // ****************************************
  // store traffic
  // ****************************************
  wire wr_meas    = meas_valid && meas_ready;
  wire fifo_wr    = (data_take && !full) || wr_meas;
  wire [7:0] fifo_wdata = wr_meas ? meas_data : bus_byte;
  wire fifo_rd    = src_state_reg == gpib_fifo_pkg::SRC_VALID &&
                    src_next == gpib_fifo_pkg::SRC_DONE && !spoll_reg &&
                    !empty && !clr;
  wire [ADDR_W:0] count_after = clr ? '0 :
    fifo_count + {{ADDR_W{1'b0}}, fifo_wr} - {{ADDR_W{1'b0}}, fifo_rd};
  wire full_evt = fifo_wr && !clr && count_after == DEPTH;
  wire meas_ready_next = xfer_active_next && count_after < DEPTH;

  fifo_store #(.WIDTH(8), .ADDR_W(ADDR_W)) u_store (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .clear   (clr),
    .wr_en   (fifo_wr),
    .wr_data (fifo_wdata),
    .rd_en   (fifo_rd),
    .rd_data (fifo_head),
    .count   (fifo_count)
  );

  // ****************************************
  // source handshake
  // ****************************************
  wire talk_active = enable && talk_reg && !atn_a && !ifc_a;
  wire have_byte   = spoll_reg || !empty;
  wire [7:0] out_byte = spoll_reg ? status_byte : fifo_head;
  wire last_byte = !spoll_reg && fmt_reg == `FMT_BINARY && fifo_count == ONE;
  wire src_idle  = src_state_reg == gpib_fifo_pkg::SRC_IDLE;

  always_comb begin
    src_next = src_state_reg;
    unique case (src_state_reg)
      gpib_fifo_pkg::SRC_IDLE:  if (have_byte) src_next = gpib_fifo_pkg::SRC_LOAD;
      gpib_fifo_pkg::SRC_LOAD:  if (!nrfd_a) src_next = gpib_fifo_pkg::SRC_VALID;
      gpib_fifo_pkg::SRC_VALID: if (!ndac_a) src_next = gpib_fifo_pkg::SRC_DONE;
      gpib_fifo_pkg::SRC_DONE:  if (ndac_a) src_next = gpib_fifo_pkg::SRC_IDLE;
    endcase
    if (!talk_active) src_next = gpib_fifo_pkg::SRC_IDLE;
  end
  wire src_off = src_next == gpib_fifo_pkg::SRC_IDLE;
  assign dio_oe_next = src_off ? 8'h00 : src_idle ? out_byte : dio_oe;
  assign eoi_oe_next = src_off ? 1'b0 : src_idle ? last_byte : eoi_oe;
  wire dav_oe_next = src_next == gpib_fifo_pkg::SRC_VALID;

  // ****************************************
  // register bus and interrupts
  // ****************************************
  wire ahb_req  = hsel && htrans[1] && hready;
  wire wr_ctrl  = bus_wr_reg && bus_addr_reg == `OFF_CTRL;
  wire wr_stat  = bus_wr_reg && bus_addr_reg == `OFF_INT_STAT;
  wire wr_mask  = bus_wr_reg && bus_addr_reg == `OFF_INT_MASK;
  wire [31:0] ctrl_word   = {23'h0, xfer_active_reg, 2'h0, ctrl_reg};
  wire [31:0] status_word = {11'h0, xfer_active_reg, spoll_reg, talk_reg,
                             prog_listen_reg, listen_reg, digits_reg, fmt_reg,
                             status_byte};
  wire [31:0] count_word  = {{(31-ADDR_W){1'b0}}, fifo_count};
  wire [7:0]  ra = haddr[7:0];
  wire [31:0] rd_word = ra == `OFF_CTRL     ? ctrl_word   :
                        ra == `OFF_STATUS   ? status_word :
                        ra == `OFF_COUNT    ? count_word  :
                        ra == `OFF_INT_STAT ? {28'h0, int_stat_reg} :
                        ra == `OFF_INT_MASK ? {28'h0, int_mask_reg} : 32'h0;

  assign ctrl_next = wr_ctrl ? hwdata[5:0] : ctrl_reg;
  // halt beats a software start in the same cycle
  assign xfer_active_next = halt ? 1'b0 : wr_ctrl ? hwdata[`CTRL_ACCUM] :
                            xfer_active_reg;
  // a new event wins over a write-one clear of the same bit
  wire [3:0] int_set = {full_evt, clr, prog_take, data_take};
  assign int_stat_next = (int_stat_reg & ~(wr_stat ? hwdata[3:0] : 4'h0)) |
                         int_set;
  assign int_mask_next = wr_mask ? hwdata[3:0] : int_mask_reg;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_wr_reg <= 1'b0;
      bus_addr_reg <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      pin_low_reg <= 1'b0;
    end else if (ce) begin
      bus_wr_reg <= ahb_req && hwrite;
      bus_addr_reg <= ahb_req ? haddr[7:0] : bus_addr_reg;
      hrdata <= (ahb_req && !hwrite) ? rd_word : hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      pin_low_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= `CTRL_RESET;
      xfer_active_reg <= 1'b0;
      int_stat_reg <= `INT_RESET;
      int_mask_reg <= `INT_RESET;
      irq <= 1'b0;
      meas_ready <= 1'b0;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      xfer_active_reg <= xfer_active_next;
      int_stat_reg <= int_stat_next;
      int_mask_reg <= int_mask_next;
      irq <= |(int_stat_next & int_mask_next);
      meas_ready <= meas_ready_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      listen_reg <= 1'b0;
      prog_listen_reg <= 1'b0;
      talk_reg <= 1'b0;
      spoll_reg <= 1'b0;
      fmt_reg <= `FMT_RESET;
      digits_reg <= `DIGITS_RESET;
      acpt_state_reg <= gpib_fifo_pkg::ACPT_READY;
      src_state_reg <= gpib_fifo_pkg::SRC_IDLE;
      prog_state_reg <= gpib_fifo_pkg::PROG_IDLE;
    end else if (ce) begin
      listen_reg <= listen_next;
      prog_listen_reg <= prog_listen_next;
      talk_reg <= talk_next;
      spoll_reg <= spoll_next;
      fmt_reg <= fmt_next;
      digits_reg <= digits_next;
      acpt_state_reg <= acpt_next;
      src_state_reg <= src_next;
      prog_state_reg <= prog_state_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ndac_oe <= 1'b0;
      nrfd_oe <= 1'b0;
      dav_oe <= 1'b0;
      eoi_oe <= 1'b0;
      dio_oe <= 8'h00;
    end else if (ce) begin
      ndac_oe <= ndac_oe_next;
      nrfd_oe <= nrfd_oe_next;
      dav_oe <= dav_oe_next;
      eoi_oe <= eoi_oe_next;
      dio_oe <= dio_oe_next;
    end
  end

  // open drain: the wire is only ever pulled low
  assign dio_out  = {8{pin_low_reg}};
  assign dav_out  = pin_low_reg;
  assign nrfd_out = pin_low_reg;
  assign ndac_out = pin_low_reg;
  assign eoi_out  = pin_low_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_src_load;
    ce && src_idle && src_next == gpib_fifo_pkg::SRC_LOAD;
  endsequence

  a_listen_ready: assert property (
    ce && listen_reg && enable && !atn_a && !ifc_a && !hold_nrfd &&
    acpt_state_reg == gpib_fifo_pkg::ACPT_READY && !dav_a
    |=> ndac_oe && !nrfd_oe && !dav_oe)
    else $error("listener not showing ready for data");
  a_unlisten_drops: assert property (
    ce && (is_unl || is_spe) |=> !listen_reg)
    else $error("unlisten or poll enable left device listening");
  a_idle_released: assert property (
    ce && !listen_reg && !atn_a && !talk_reg |=> !ndac_oe && !nrfd_oe &&
    !dav_oe)
    else $error("handshake lines not released when idle");
  a_untalk_silent: assert property (
    ce && !talk_active |=> !dav_oe && dio_oe == 8'h00)
    else $error("untalked device sourced a byte");
  a_talk_byte: assert property (
    s_src_load |=> dio_oe == $past(out_byte))
    else $error("talked byte not placed on the data lines");
  a_full_nrfd: assert property (
    ce && engaged && !atn_a && hold_nrfd |=> nrfd_oe)
    else $error("nrfd released while full or accumulating");
  a_full_refuse: assert property (
    full |-> !fifo_wr)
    else $error("byte written into a full store");
  a_halt_stops: assert property (
    ce && halt |=> !xfer_active_reg ##1 !meas_ready)
    else $error("halt did not stop the source transfer");
  a_clear_empty: assert property (
    ce && clr |=> fifo_count == '0 && status_byte == 8'h00)
    else $error("clear did not empty the store");
  a_one_byte_stat: assert property (
    fifo_count == ONE |-> status_byte == 8'h08)
    else $error("single byte status not octal 10");
  a_eoi_last: assert property (
    s_src_load ##0 last_byte |=> eoi_oe)
    else $error("eoi missing on last binary byte");
endmodule : gpib_measurement_fifo

/* File: gpib_fifo_defs.svh */
// register offsets, field positions, command codes and reset values
`ifndef GPIB_FIFO_DEFS_SVH
`define GPIB_FIFO_DEFS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_COUNT     8'h08
`define OFF_INT_STAT  8'h0C
`define OFF_INT_MASK  8'h10

// ****************************************
// field positions and reset values
// ****************************************
`define CTRL_ENABLE   0
`define CTRL_ADDR_LO  1
`define CTRL_ADDR_HI  5
`define CTRL_ACCUM    8
`define CTRL_RESET    6'h05
`define INT_DATA      0
`define INT_PROG      1
`define INT_CLEAR     2
`define INT_FULL      3
`define INT_RESET     4'h0
`define FMT_RESET     4'h2
`define DIGITS_RESET  4'h1
`define PIN_RESET     13'h1FFF

// ****************************************
// bus commands, sent with attention asserted
// ****************************************
`define CMD_UNL       7'h3F
`define CMD_SPE       7'h18
`define CMD_SPD       7'h19
`define CMD_DCL       7'h14
`define CMD_SDC       7'h04
`define GRP_LISTEN    2'h1
`define GRP_TALK      2'h2

// ****************************************
// program codes, sent at the program address
// ****************************************
`define PC_HALT       8'h48
`define PC_FORMAT     8'h46
`define PC_DIGITS     8'h54
`define PC_CLEAR      8'h52
`define PC_DIGIT_GRP  4'h3
`define FMT_BINARY    4'h2

`endif

/* File: gpib_fifo_pkg.sv */
// state types shared by the measurement store
package gpib_fifo_pkg;
  typedef enum logic {ACPT_READY, ACPT_HOLD} acpt_state_e;
  typedef enum logic [1:0] {SRC_IDLE, SRC_LOAD, SRC_VALID, SRC_DONE}
    src_state_e;
  typedef enum logic [1:0] {PROG_IDLE, PROG_FORMAT, PROG_DIGITS}
    prog_state_e;
endpackage : gpib_fifo_pkg

/* File: fifo_store.sv */
// byte store with write and read address counters
`timescale 1ns/1ps
module fifo_store #(
  parameter int WIDTH  = 8,
  parameter int ADDR_W = 11
) (
  // clock and control
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic              clear,
  // write side
  input  wire logic              wr_en,
  input  wire logic [WIDTH-1:0]  wr_data,
  // read side
  input  wire logic              rd_en,
  output logic      [WIDTH-1:0]  rd_data,
  output logic      [ADDR_W:0]   count
);
  logic [WIDTH-1:0] mem_reg [0:(1<<ADDR_W)-1];
  logic [ADDR_W:0]  wr_ptr_reg;
  logic [ADDR_W:0]  rd_ptr_reg;

  // equal counters mean empty; the extra bit tells full from empty
  assign count   = wr_ptr_reg - rd_ptr_reg;
  assign rd_data = mem_reg[rd_ptr_reg[ADDR_W-1:0]];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (ce) begin
      if (clear) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else begin
        if (wr_en) wr_ptr_reg <= wr_ptr_reg + 1'b1;
        if (rd_en) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // all bits stored independently; no reset on the array
  always_ff @(posedge ref_clk) begin
    if (ce && wr_en && !clear) mem_reg[wr_ptr_reg[ADDR_W-1:0]] <= wr_data;
  end

  a_write_advance: assert property (@(posedge ref_clk) disable iff (reset)
    ce && wr_en && !clear |=> wr_ptr_reg == $past(wr_ptr_reg) + 1'b1)
    else $error("write counter did not advance by one");
  a_clear_zeroes: assert property (@(posedge ref_clk) disable iff (reset)
    ce && clear |=> wr_ptr_reg == '0 && rd_ptr_reg == '0)
    else $error("clear left an address counter nonzero");
endmodule : fifo_store

/* File: ctlr.sv */
// instrument bus controller model facing the measurement store
`timescale 1ns/1ps
module ctlr (
  // clock
  input  wire logic       ref_clk,
  // device drive enables
  input  wire logic       dav_oe,
  input  wire logic       nrfd_oe,
  input  wire logic       ndac_oe,
  input  wire logic       eoi_oe,
  input  wire logic [7:0] dio_oe,
  // wire levels, low asserted
  output logic            dav_in,
  output logic            nrfd_in,
  output logic            ndac_in,
  output logic            atn_in,
  output logic      [7:0] dio_in
);
  logic [7:0] d_r = 8'h00;
  logic       dav_r = 1'h0, atn_r = 1'h0;
  // held while idle so a talker cannot pop a byte unseen
  logic       nrfd_r = 1'h1, ndac_r = 1'h1;
  // released lines float high on the pull-ups
  assign dio_in  = ~(d_r | dio_oe);
  assign dav_in  = ~(dav_r | dav_oe);
  assign nrfd_in = ~(nrfd_r | nrfd_oe);
  assign ndac_in = ~(ndac_r | ndac_oe);
  assign atn_in  = ~atn_r;
  task automatic send(input logic a, input logic [7:0] c);
    @(posedge ref_clk);
    atn_r <= a;
    d_r   <= c;
    do @(posedge ref_clk); while (nrfd_oe || !ndac_oe);
    dav_r <= 1'h1;
    do @(posedge ref_clk); while (ndac_oe);
    dav_r <= 1'h0;
    d_r   <= 8'h00;
    atn_r <= 1'h0;
  endtask : send
  task automatic recv(output logic [7:0] c, output logic e);
    @(posedge ref_clk);
    nrfd_r <= 1'h0;
    do @(posedge ref_clk); while (!dav_oe);
    c = dio_oe;
    e = eoi_oe;
    nrfd_r <= 1'h1;
    ndac_r <= 1'h0;
    do @(posedge ref_clk); while (dav_oe);
    ndac_r <= 1'h1;
  endtask : recv
endmodule : ctlr

/* File: test_gpib_measurement_fifo.sv */
// self-checking bench for the measurement store
`timescale 1ns/1ps
module test_gpib_measurement_fifo;
  logic        ref_clk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic        ce = 1'h1, meas_valid = 1'h0, hresp, meas_ready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, irq, dav_in, nrfd_in, ndac_in, atn_in, e;
  logic        dav_oe, nrfd_oe, ndac_oe, eoi_oe;
  logic [7:0]  dio_in, dio_oe, b, v, meas_data = 8'h00;
  int          mismatches = 0, num_checks = 0;
  gpib_measurement_fifo #(.ADDR_W(4)) gpib_measurement_fifo_inst (
    .ref_clk, .reset, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .irq, .dio_in, .dio_out(), .dio_oe, .dav_in, .dav_out(),
    .dav_oe, .nrfd_in, .nrfd_out(), .nrfd_oe, .ndac_in, .ndac_out(),
    .ndac_oe, .eoi_out(), .eoi_oe, .atn_in, .ifc_in(1'h1),
    .meas_valid, .meas_data, .meas_ready);
  ctlr ctlr_inst (.ref_clk, .dio_oe, .dav_oe, .nrfd_oe, .ndac_oe,
    .eoi_oe, .dio_in, .dav_in, .nrfd_in, .ndac_in, .atn_in);
  initial forever #4 ref_clk = ~ref_clk;
  // ceiling well above the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic cmp(input string n, input logic [31:0] x, s);
    num_checks++;
    if (s !== x) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", n, x, s);
    end
  endtask : cmp
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : ahb
  task automatic tx(input logic a, input logic [7:0] c);
    ctlr_inst.send(a, c);
  endtask : tx
  task automatic hs(input logic [7:0] c, input logic [2:0] x);
    tx(1'h1, c);
    repeat (8) @(posedge ref_clk);
    cmp("handshake", 32'(x), 32'({ndac_oe, nrfd_oe, dav_oe}));
  endtask : hs
  // program address takes two codes, data address one byte
  task automatic lsn(input logic [7:0] a, input logic [15:0] c);
    tx(1'h1, a);
    if (a == 8'h22)
      tx(1'h0, c[15:8]);
    tx(1'h0, c[7:0]);
    tx(1'h1, 8'h3F);
  endtask : lsn
  task automatic talk(input logic [7:0] x, input logic xe, pm);
    if (pm)
      tx(1'h1, 8'h18);
    tx(1'h1, 8'h42);
    ctlr_inst.recv(b, e);
    tx(1'h1, pm ? 8'h19 : 8'h5F);
    tx(1'h1, 8'h5F);
    cmp("byte", 32'(x), 32'(b));
    if (!pm)
      cmp("eoi", 32'(xe), 32'(e));
  endtask : talk
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'h0;
    hs(8'h22, 3'h4);
    hs(8'h3F, 3'h0);
    hs(8'h23, 3'h4);
    hs(8'h18, 3'h0);
    cmp("talk idle", 32'h0, 32'(dav_oe));
    talk(8'h00, 1'h0, 1'h1);
    lsn(8'h22, "T4");
    ahb(1'h0, 8'h04, 32'h0);
    cmp("digits", 32'h4, 32'(rd[15:12]));
    lsn(8'h22, "F2");
    lsn(8'h22, "T1");
    ahb(1'h0, 8'h04, 32'h0);
    cmp("format", 32'h12, 32'(rd[15:8]));
    $display("addressing test done");
    for (int i = 0; i < 9; i++) begin
      v = (i < 8) ? 8'h01 << i : 8'h00;
      lsn(8'h22, "HR");
      lsn(8'h23, {8'h00, v});
      talk(v, 1'h1, 1'h0);
    end
    for (int m = 0; m < 3; m++) begin
      lsn(8'h23, 16'h0000);
      talk(8'h08, 1'h0, 1'h1);
      v = (m == 0) ? 8'h52 : (m == 1) ? 8'h04 : 8'h14;
      tx(1'h1, 8'h22);
      tx(m != 0, v);
      tx(1'h1, 8'h3F);
      talk(8'h00, 1'h0, 1'h1);
    end
    $display("clear test done");
    // source byte offered while frozen must land exactly once
    ahb(1'h1, 8'h00, 32'h105);
    ce         <= 1'h0;
    meas_valid <= 1'h1;
    meas_data  <= 8'h5A;
    repeat (4) @(posedge ref_clk);
    ce <= 1'h1;
    do @(posedge ref_clk); while (meas_ready !== 1'h1);
    meas_valid <= 1'h0;
    tx(1'h1, 8'h23);
    repeat (8) @(posedge ref_clk);
    cmp("busy", 32'h1, 32'(nrfd_oe));
    tx(1'h1, 8'h3F);
    lsn(8'h22, 16'h4800);
    cmp("halted", 32'h0, 32'(meas_ready));
    ahb(1'h0, 8'h08, 32'h0);
    cmp("frozen count", 32'h1, rd);
    talk(8'h5A, 1'h1, 1'h0);
    $display("source test done");
    ahb(1'h1, 8'h10, 32'h8);
    @(posedge ref_clk);
    cmp("irq masked", 32'h0, 32'(irq));
    for (int i = 0; i < 16; i++)
      lsn(8'h23, {8'h00, 8'hA0 + 8'(i)});
    talk(8'h10, 1'h0, 1'h1);
    tx(1'h1, 8'h23);
    repeat (8) @(posedge ref_clk);
    cmp("refuse", 32'h1, 32'(nrfd_oe));
    tx(1'h1, 8'h3F);
    ahb(1'h0, 8'h08, 32'h0);
    cmp("count", 32'h10, rd);
    cmp("irq", 32'h1, 32'(irq));
    for (int i = 0; i < 16; i++)
      talk(8'hA0 + 8'(i), i == 15, 1'h0);
    ahb(1'h1, 8'h0C, 32'hF);
    ahb(1'h0, 8'h40, 32'h0);
    cmp("unmapped", 32'h0, rd);
    cmp("hresp", 32'h0, 32'(hresp));
    cmp("irq", 32'h0, 32'(irq));
    $display("store test done");
    finish_test();
  end
endmodule : test_gpib_measurement_fifo
